/* logic/sac_consts.svh */
// Constants for the compare converter control block
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

`define SAC_CNT_W 5
`define SAC_ADDR_W 7
`define SAC_BUF_W 12
`define SAC_REF_W 8
`define SAC_ADDR_REF 7'h02
`define SAC_REF_RST 8'h00
`define SAC_SAR_FIRST 8'h80
`define SAC_BIT_CMP 0
`define SAC_BIT_ACT 1
`define SAC_BIT_MODE 2
`define SAC_SW_CMP_CYC 5'h03
`define SAC_HW_ACT_CLR_CYC 5'h0f
`define SAC_HW_DONE_CYC 5'h11
`define SAC_HW_LAST_STEP 5'h10
`define SAC_CNT_MAX 5'h1f
`define SAC_STEP_TOP 4'h8

`endif

/* logic/sac_ctrl.sv */
// Control of the comparator-based converter: reference/result and mode flags
// ----------------------------------------------------------------------------
// Notes on behaviour
// RQ1: Mode bit written zero aborts conversion
// RQ2: Mode bit written one starts hardware conversion
// RQ3: Software mode: store to reference starts compare
// RQ4: Eight-bit reference register at address 02H
// RQ5: Software mode: reference selects compare level
// RQ6: Hardware mode: reading reference returns result
// RQ7: Code zero gives zero, else (x-0.5)/256
// RQ8: CE reset, clock stop clear only hardware
// RQ9: Software compare flag valid three cycles later
// RQ10: Hardware start sets active flag
// RQ11: Hardware result final seventeen cycles after start
// RQ12: Active flag clears fifteen cycles after start
// RQ13: Software polls active flag before reading result
// RQ14: Mode register: compare b0, active b1, mode b2
// RQ15: Compare flag reports input above level
// RQ16: Hardware steps reference without software help
// RQ17: Bits decided most significant first
// RQ18: Low two nibbles carry data, third ignored
// ----------------------------------------------------------------------------
`include "sac_consts.svh"

module sac_ctrl
  import sac_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_instr_cycle,
  input wire logic [`SAC_ADDR_W-1:0] i_periph_addr,
  input wire logic i_buffer_store_instruction,
  input wire logic i_buffer_load_instruction,
  input wire logic [`SAC_BUF_W-1:0] i_transfer_buffer,
  output logic [`SAC_BUF_W-1:0] o_transfer_buffer,
  input wire logic i_mode_wr,
  input wire logic i_mode_wdata,
  output logic [3:0] o_conv_mode_select,
  input wire logic i_ce_reset,
  input wire logic i_clock_stop,
  input wire logic i_analog_input_above,
  output logic [`SAC_REF_W-1:0] o_compare_level
);

  // --------------------------------------------------------------------------
  // Submodules
  // --------------------------------------------------------------------------
  sac_tmr_if tmr_if ();

  sac_cycle_timer u_timer (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .tmr(tmr_if.tmr)
  );

  logic above;

  sac_sync3 u_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_async(i_analog_input_above),
    .o_level(above)
  );

  // --------------------------------------------------------------------------
  // Control state
  // --------------------------------------------------------------------------
  sac_ctl_t ctl_r;
  sac_ctl_t ctl_nxt;
  logic tmr_start;
  logic tmr_stop;
  logic ref_sel;
  logic [`SAC_CNT_W-1:0] next_cnt;
  logic [3:0] step;
  logic [2:0] bit_idx;

  assign ref_sel = (i_periph_addr == `SAC_ADDR_REF); // see RQ4
  assign next_cnt = tmr_if.elapsed + 5'h01;
  assign step = next_cnt[4:1];
  assign bit_idx = 3'(`SAC_STEP_TOP - step);

  always_comb begin
    ctl_nxt = ctl_r;
    tmr_start = 1'b0;
    tmr_stop = 1'b0;
    if (i_ce_reset || i_clock_stop) begin
      // Result in hardware mode is meaningless after a stop, so drop it
      ctl_nxt.state = sac_st_idle;
      ctl_nxt.active = 1'b0;
      tmr_stop = 1'b1;
      if (ctl_r.mode) begin
        ctl_nxt.ref_code = `SAC_REF_RST; // see RQ8
      end
      if (i_ce_reset) begin
        ctl_nxt.cmp = 1'b0;
      end
    end else if (i_mode_wr) begin
      ctl_nxt.mode = i_mode_wdata;
      if (i_mode_wdata) begin
        ctl_nxt.state = sac_st_hw_conv; // see RQ2
        ctl_nxt.active = 1'b1; // see RQ10
        ctl_nxt.ref_code = `SAC_SAR_FIRST; // see RQ17
        tmr_start = 1'b1;
      end else begin
        ctl_nxt.state = sac_st_idle; // see RQ1
        ctl_nxt.active = 1'b0;
        tmr_stop = 1'b1;
      end
    end else begin
      case (ctl_r.state)
        sac_st_sw_cmp: begin
          if (i_instr_cycle && next_cnt == `SAC_SW_CMP_CYC) begin
            ctl_nxt.cmp = above; // see RQ9
            ctl_nxt.state = sac_st_idle;
            tmr_stop = 1'b1;
          end
        end
        sac_st_hw_conv: begin
          if (i_instr_cycle) begin
            if (next_cnt == `SAC_HW_ACT_CLR_CYC) begin
              // Two cycles early so the poll loop sees the end in time
              ctl_nxt.active = 1'b0; // see RQ12
            end
            if (!next_cnt[0] && next_cnt <= `SAC_HW_LAST_STEP && step != 4'h0) begin
              if (!above) begin
                ctl_nxt.ref_code[bit_idx] = 1'b0; // see RQ17
              end
              if (bit_idx != 3'h0) begin
                ctl_nxt.ref_code[bit_idx-3'h1] = 1'b1; // see RQ16
              end
            end
            if (next_cnt == `SAC_HW_DONE_CYC) begin
              ctl_nxt.state = sac_st_idle; // see RQ11
              tmr_stop = 1'b1;
            end
          end
        end
        default: begin
          ctl_nxt.state = sac_st_idle;
        end
      endcase
      if (i_buffer_store_instruction && ref_sel) begin
        if (!ctl_r.mode) begin
          // Third nibble is don't care on stores
          ctl_nxt.ref_code = i_transfer_buffer[`SAC_REF_W-1:0]; // see RQ18
          ctl_nxt.state = sac_st_sw_cmp; // see RQ3
          tmr_start = 1'b1;
        end else if (ctl_r.state != sac_st_hw_conv) begin
          ctl_nxt.ref_code = i_transfer_buffer[`SAC_REF_W-1:0];
        end
      end
    end
    if (i_buffer_load_instruction && ref_sel) begin
      ctl_nxt.rd_data = {4'h0, ctl_r.ref_code}; // see RQ6
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ctl_r <= '0; // see RQ8
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  assign tmr_if.start = tmr_start;
  assign tmr_if.stop = tmr_stop;
  assign tmr_if.tick = i_instr_cycle;

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign o_transfer_buffer = ctl_r.rd_data;
  // Tap code for the resistor string; level is (code-0.5)/256 of supply, zero for code 0
  assign o_compare_level = ctl_r.ref_code; // see RQ5 see RQ7
  always_comb begin
    o_conv_mode_select = 4'h0;
    o_conv_mode_select[`SAC_BIT_CMP] = ctl_r.cmp; // see RQ14 see RQ15
    o_conv_mode_select[`SAC_BIT_ACT] = ctl_r.active;
    o_conv_mode_select[`SAC_BIT_MODE] = ctl_r.mode;
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic quiet;
  assign quiet = !(i_mode_wr || i_ce_reset || i_clock_stop);

  property p_abort;
    @(posedge i_clk) disable iff (!i_nrst)
    (i_mode_wr && !i_mode_wdata && !i_ce_reset && !i_clock_stop)
      |=> (!o_conv_mode_select[1] && ctl_r.state == sac_st_idle);
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not stop conversion"); // see RQ1

  property p_hw_start;
    @(posedge i_clk) disable iff (!i_nrst)
    (i_mode_wr && i_mode_wdata && !i_ce_reset && !i_clock_stop)
      |=> (o_conv_mode_select[1] && o_conv_mode_select[2] && o_compare_level == `SAC_SAR_FIRST);
  endproperty
  a_hw_start: assert property (p_hw_start) else $error("hardware start wrong"); // see RQ10

  property p_sw_store;
    @(posedge i_clk) disable iff (!i_nrst)
    (quiet && i_buffer_store_instruction && ref_sel && !ctl_r.mode)
      |=> (ctl_r.state == sac_st_sw_cmp && o_compare_level == $past(i_transfer_buffer[7:0]));
  endproperty
  a_sw_store: assert property (p_sw_store) else $error("store did not start compare"); // see RQ3

  property p_read;
    @(posedge i_clk) disable iff (!i_nrst)
    (i_buffer_load_instruction && ref_sel)
      |=> (o_transfer_buffer == {4'h0, $past(ctl_r.ref_code)});
  endproperty
  a_read: assert property (p_read) else $error("read data mismatch"); // see RQ6

  property p_sw_three;
    @(posedge i_clk) disable iff (!i_nrst)
    (quiet && !i_buffer_store_instruction && ctl_r.state == sac_st_sw_cmp
      && i_instr_cycle && tmr_if.elapsed == (`SAC_SW_CMP_CYC - 5'h01))
      |=> (ctl_r.state == sac_st_idle && o_conv_mode_select[0] == $past(above));
  endproperty
  a_sw_three: assert property (p_sw_three) else $error("compare flag not latched at three"); // see RQ9

  property p_act_clr;
    @(posedge i_clk) disable iff (!i_nrst)
    (quiet && ctl_r.state == sac_st_hw_conv && i_instr_cycle && tmr_if.elapsed == (`SAC_HW_ACT_CLR_CYC - 5'h01))
      |=> (!o_conv_mode_select[1] && ctl_r.state == sac_st_hw_conv);
  endproperty
  a_act_clr: assert property (p_act_clr) else $error("active flag not cleared at fifteen"); // see RQ12

  property p_done;
    @(posedge i_clk) disable iff (!i_nrst)
    (quiet && ctl_r.state == sac_st_hw_conv && i_instr_cycle && tmr_if.elapsed == (`SAC_HW_DONE_CYC - 5'h01))
      |=> (ctl_r.state == sac_st_idle && $stable(o_compare_level));
  endproperty
  a_done: assert property (p_done) else $error("conversion not done at seventeen"); // see RQ11

  property p_ce_hw;
    @(posedge i_clk) disable iff (!i_nrst)
    ((i_ce_reset || i_clock_stop) && ctl_r.mode) |=> (o_compare_level == `SAC_REF_RST);
  endproperty
  a_ce_hw: assert property (p_ce_hw) else $error("hardware result not cleared"); // see RQ8

  property p_ce_sw;
    @(posedge i_clk) disable iff (!i_nrst)
    ((i_ce_reset || i_clock_stop) && !ctl_r.mode) |=> $stable(o_compare_level);
  endproperty
  a_ce_sw: assert property (p_ce_sw) else $error("software reference lost"); // see RQ8

  property p_hw_hold;
    @(posedge i_clk) disable iff (!i_nrst)
    (quiet && ctl_r.state == sac_st_hw_conv && !i_instr_cycle) |=> $stable(o_compare_level);
  endproperty
  a_hw_hold: assert property (p_hw_hold) else $error("reference moved off a cycle"); // see RQ16

  property p_ce_flags;
    @(posedge i_clk) disable iff (!i_nrst)
    i_ce_reset
      |=> (!o_conv_mode_select[`SAC_BIT_CMP] && !o_conv_mode_select[`SAC_BIT_ACT]);
  endproperty
  a_ce_flags: assert property (p_ce_flags) else $error("CE reset left a flag set"); // see RQ8

  property p_stop_flags;
    @(posedge i_clk) disable iff (!i_nrst)
    (i_clock_stop && !i_ce_reset)
      |=> ($stable(o_conv_mode_select[`SAC_BIT_CMP]) && !o_conv_mode_select[`SAC_BIT_ACT]);
  endproperty
  a_stop_flags: assert property (p_stop_flags) else $error("clock stop flags wrong"); // see RQ8

  property p_mode_keep;
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce_reset || i_clock_stop) |=> $stable(o_conv_mode_select[`SAC_BIT_MODE]);
  endproperty
  a_mode_keep: assert property (p_mode_keep) else $error("mode bit lost on stop"); // see RQ14

  property p_other_addr;
    @(posedge i_clk) disable iff (!i_nrst)
    (quiet && i_buffer_store_instruction && !ref_sel && ctl_r.state != sac_st_hw_conv)
      |=> $stable(o_compare_level);
  endproperty
  a_other_addr: assert property (p_other_addr) else $error("store to other address landed"); // see RQ4

  property p_load_hold;
    @(posedge i_clk) disable iff (!i_nrst)
    !(i_buffer_load_instruction && ref_sel) |=> $stable(o_transfer_buffer);
  endproperty
  a_load_hold: assert property (p_load_hold) else $error("read data moved without a load"); // see RQ6

  property p_sar_msb;
    @(posedge i_clk) disable iff (!i_nrst)
    (quiet && ctl_r.state == sac_st_hw_conv && i_instr_cycle && !next_cnt[0] && step == 4'h1)
      |=> (o_compare_level[`SAC_REF_W-1] == $past(above) && o_compare_level[`SAC_REF_W-2]);
  endproperty
  a_sar_msb: assert property (p_sar_msb) else $error("top bit decision wrong"); // see RQ17

  property p_sar_lsb;
    @(posedge i_clk) disable iff (!i_nrst)
    (quiet && ctl_r.state == sac_st_hw_conv && i_instr_cycle && next_cnt == `SAC_HW_LAST_STEP)
      |=> (o_compare_level[0] == $past(above));
  endproperty
  a_sar_lsb: assert property (p_sar_lsb) else $error("last bit decision wrong"); // see RQ17

  property p_act_mode;
    @(posedge i_clk) disable iff (!i_nrst)
    o_conv_mode_select[`SAC_BIT_ACT] |-> o_conv_mode_select[`SAC_BIT_MODE];
  endproperty
  a_act_mode: assert property (p_act_mode) else $error("active flag outside hardware mode"); // see RQ10

endmodule : sac_ctrl

/* logic/sac_cycle_timer.sv */
// Counter of instruction cycles since a conversion start
`include "sac_consts.svh"

module sac_cycle_timer
  import sac_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  sac_tmr_if.tmr tmr
);

  sac_tmr_t tmr_r;
  sac_tmr_t tmr_nxt;

  // Start beats stop so a fresh start can restart a running count
  always_comb begin
    tmr_nxt = tmr_r;
    if (tmr.start) begin
      tmr_nxt.running = 1'b1;
      tmr_nxt.elapsed = '0;
    end else if (tmr.stop) begin
      tmr_nxt.running = 1'b0;
      tmr_nxt.elapsed = '0;
    end else if (tmr_r.running && tmr.tick && tmr_r.elapsed != `SAC_CNT_MAX) begin
      tmr_nxt.elapsed = tmr_r.elapsed + 5'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      tmr_r <= '0;
    end else begin
      tmr_r <= tmr_nxt;
    end
  end

  assign tmr.elapsed = tmr_r.elapsed;
  assign tmr.running = tmr_r.running;

endmodule : sac_cycle_timer

/* logic/sac_pkg.sv */
// Types shared by the compare converter control modules
`include "sac_consts.svh"

package sac_pkg;

  typedef enum logic [1:0] {
    sac_st_idle,
    sac_st_sw_cmp,
    sac_st_hw_conv
  } sac_state_t;

  typedef struct packed {
    sac_state_t state;
    logic [`SAC_REF_W-1:0] ref_code;
    logic mode;
    logic active;
    logic cmp;
    logic [`SAC_BUF_W-1:0] rd_data;
  } sac_ctl_t;

  typedef struct packed {
    logic [`SAC_CNT_W-1:0] elapsed;
    logic running;
  } sac_tmr_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } sac_sync_t;

endpackage : sac_pkg

/* logic/sac_sync3.sv */
// Three-stage synchroniser for the comparator level
`include "sac_consts.svh"

module sac_sync3
  import sac_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_async,
  output logic o_level
);

  sac_sync_t sync_r;
  sac_sync_t sync_nxt;

  // First stage feeds only the second; change accepted once s2 and s3 agree
  always_comb begin
    sync_nxt = sync_r;
    sync_nxt.s1 = i_async;
    sync_nxt.s2 = sync_r.s1;
    sync_nxt.s3 = sync_r.s2;
    if (sync_r.s2 == sync_r.s3) begin
      sync_nxt.q = sync_r.s3;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      sync_r <= '0;
    end else begin
      sync_r <= sync_nxt;
    end
  end

  assign o_level = sync_r.q;

endmodule : sac_sync3

/* logic/sac_tmr_if.sv */
// Instruction-cycle timer link between controller and timer
`include "sac_consts.svh"

interface sac_tmr_if;
  logic start;
  logic stop;
  logic tick;
  logic [`SAC_CNT_W-1:0] elapsed;
  logic running;

  modport ctl (
    output start,
    output stop,
    output tick,
    input elapsed,
    input running
  );

  modport tmr (
    input start,
    input stop,
    input tick,
    output elapsed,
    output running
  );
endinterface : sac_tmr_if

/* verif/sac_far_model.sv */
// Far-side model: instruction-cycle pacer and analog comparator
module sac_far_model (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [8:0] i_vin_half,
  input wire logic [7:0] i_level,
  output logic o_instr_cycle,
  output logic o_above
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div_r = 3'h0;
  initial o_instr_cycle = 1'b0;
  // Input in half steps; code x sits at 2x-1, code 0 at zero
  assign o_above = (i_level == 8'h00) ? (i_vin_half != 9'h000)
                 : (i_vin_half > ({1'b0, i_level} * 9'h002 - 9'h001));
  // One pulse every 8 clocks, like a slow core
  always @(posedge i_clk) begin
    div_r <= #1 i_nrst ? div_r + 3'h1 : 3'h0;
    o_instr_cycle <= #1 i_nrst && (div_r == 3'h7);
  end
endmodule : sac_far_model

/* verif/tb_top.sv */
// Self-checking bench for the compare converter control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic tick, st, ld, mwr, mwd, ce, cs, above;
  logic [6:0] addr;
  logic [11:0] wbuf, rbuf, d;
  logic [3:0] flags;
  logic [7:0] level;
  logic [8:0] vin;
  int mismatches = 0;
  int checks_done = 0;
  logic [7:0] sw_code [3] = '{8'h7f, 8'h00, 8'h01};
  logic [8:0] sw_vin [3] = '{9'h0fe, 9'h000, 9'h002};
  logic sw_exp [3] = '{1'b1, 1'b0, 1'b1};
  logic [7:0] hw_res [3] = '{8'ha5, 8'h00, 8'hff};
  logic prev;

  always #12.5 clk = ~clk;

  sac_ctrl dut_u (.i_clk(clk), .i_nrst(nrst), .i_instr_cycle(tick), .i_periph_addr(addr),
    .i_buffer_store_instruction(st), .i_buffer_load_instruction(ld), .i_transfer_buffer(wbuf),
    .o_transfer_buffer(rbuf), .i_mode_wr(mwr), .i_mode_wdata(mwd), .o_conv_mode_select(flags),
    .i_ce_reset(ce), .i_clock_stop(cs), .i_analog_input_above(above), .o_compare_level(level));

  sac_far_model far_u (.i_clk(clk), .i_nrst(nrst), .i_vin_half(vin), .i_level(level),
    .o_instr_cycle(tick), .o_above(above));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    checks_done++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask : chk

  task tk(input int n);
    repeat (n) @(posedge clk iff tick);
    #2;
  endtask : tk

  task store(input logic [6:0] a, input logic [11:0] v);
    @(posedge clk) #1 addr = a;
    wbuf = v;
    st = 1'b1;
    @(posedge clk) #1 st = 1'b0;
  endtask : store

  task load(output logic [11:0] v);
    @(posedge clk) #1 addr = 7'h02;
    ld = 1'b1;
    @(posedge clk) #1 ld = 1'b0;
    v = rbuf;
  endtask : load

  task mode(input logic b);
    @(posedge clk) #1 mwd = b;
    mwr = 1'b1;
    @(posedge clk) #1 mwr = 1'b0;
  endtask : mode

  task hit(input int k);
    @(posedge clk) #1 ce = (k == 0);
    cs = (k != 0);
    @(posedge clk) #1 ce = 1'b0;
    cs = 1'b0;
  endtask : hit

  task test_done;
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {st, ld, mwr, mwd, ce, cs} = 6'h00;
    addr = 7'h00;
    wbuf = 12'h000;
    vin = 9'h000;
    prev = 1'b0;
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    tk(1);
    chk("flags_rst", 12'h000, {8'h00, flags});
    store(7'h03, 12'h0ff);
    load(d);
    chk("ref_rst", 12'h000, d);
    for (int i = 0; i < 3; i++) begin
      vin = sw_vin[i];
      tk(1);
      store(7'h02, {4'hf, sw_code[i]});
      chk("level", {4'h0, sw_code[i]}, {4'h0, level});
      tk(2);
      chk("cmp_early", {11'h000, prev}, {11'h000, flags[0]});
      tk(1);
      chk("cmp", {11'h000, sw_exp[i]}, {11'h000, flags[0]});
      prev = sw_exp[i];
      load(d);
      chk("sw_read", {4'h0, sw_code[i]}, d);
    end
    for (int i = 0; i < 3; i++) begin
      vin = {hw_res[i], 1'b0};
      tk(1);
      mode(1'b1);
      chk("hw_start", 12'h006, {8'h00, flags & 4'h6});
      tk(14);
      chk("act14", 12'h002, {8'h00, flags & 4'h2});
      tk(1);
      chk("act15", 12'h000, {8'h00, flags & 4'h2});
      tk(2);
      load(d);
      chk("hw_res", {4'h0, hw_res[i]}, d);
    end
    store(7'h02, 12'h03c);
    load(d);
    chk("hw_store", 12'h03c, d);
    chk("hw_idle", 12'h004, {8'h00, flags & 4'h6});
    tk(1);
    mode(1'b1);
    tk(5);
    store(7'h02, 12'h0c3);
    mode(1'b0);
    tk(1);
    chk("abort", 12'h000, {8'h00, flags & 4'h6});
    load(d);
    chk("hw_refuse", 12'h0e0, d);
    for (int i = 0; i < 2; i++) begin
      tk(1);
      mode(1'b1);
      tk(17);
      hit(1 - i);
      chk("hw_flags", {9'h000, 1'b1, 1'b0, i == 0}, {8'h00, flags});
      load(d);
      chk("hw_keep", 12'h000, d);
      tk(1);
      mode(1'b0);
      store(7'h02, 12'h05a);
      hit(1 - i);
      chk("sw_flags", {11'h000, i == 0}, {8'h00, flags});
      load(d);
      chk("sw_keep", 12'h05a, d);
    end
    mode(1'b1);
    @(posedge clk) #1 nrst = 1'b0;
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    chk("flags_nrst", 12'h000, {8'h00, flags});
    load(d);
    chk("ref_nrst", 12'h000, d);
    test_done();
  end

  initial begin
    #150000;
    mismatches++;
    test_done();
  end
endmodule : tb_top
